// file: core/crb_rx_store.sv
// Receive buffers, shared reception FIFOs and receive-mode TX/RX FIFOs
`timescale 1ns/1ps

module crb_rx_store
  import crb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire crb_store_t store_in,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [FIFO_N-1:0] fifo_irq,
  output logic global_err_irq
);

  logic msg_lost_irq_enable_r;
  logic [RXBUF_N-1:0] rxbuf_new_flag_r;
  crb_msg_t rxbuf_mem_r [RXBUF_N];
  logic [31:0] rd_data_r;
  logic [FIFO_N-1:0] fifo_irq_r;
  logic global_err_irq_r;

  logic [31:0] fifo_cfg [FIFO_N];
  logic [31:0] fifo_sts [FIFO_N];
  crb_msg_t fifo_head [FIFO_N];
  logic [FIFO_N-1:0] fifo_lost;
  logic [FIFO_N-1:0] fifo_irq_req;

  logic in_global;
  logic in_fifo;
  logic in_rxbuf;
  logic [3:0] fifo_sel;
  logic [2:0] fifo_word;
  logic [2:0] rxbuf_sel;
  logic [1:0] rxbuf_word;
  logic fifo_sel_ok;

  assign in_global = (reg_addr[11:4] == 8'h00);
  assign in_fifo = (reg_addr[11:9] == FIFO_REGION);
  assign in_rxbuf = (reg_addr[11:7] == RXBUF_REGION);
  assign fifo_sel = reg_addr[8:5];
  assign fifo_word = reg_addr[4:2];
  assign rxbuf_sel = reg_addr[6:4];
  assign rxbuf_word = reg_addr[3:2];
  assign fifo_sel_ok = (fifo_sel < 4'(FIFO_N));

  // Global control: module-wide loss interrupt enable
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      msg_lost_irq_enable_r <= 1'b0;
    end else if (reg_wr && in_global && reg_addr == GLOBAL_CONTROL_OFS) begin
      msg_lost_irq_enable_r <= reg_wdata[GCTL_MSG_LOST_IRQ_ENABLE_BIT];
    end
  end

  // Reception buffers: plain overwrite, no interrupt path exists here
  always_ff @(posedge clk_sys) begin
    if (store_in.valid && !store_in.to_fifo && store_in.index < 4'(RXBUF_N)) begin
      rxbuf_mem_r[store_in.index[2:0]] <= store_in.msg;
    end
  end

  // New-data flags; a store in the clearing cycle wins
  genvar q;
  generate
    for (q = 0; q < RXBUF_N; q++) begin : g_newflag
      logic set_q;
      logic clr_q;
      assign set_q = store_in.valid && !store_in.to_fifo && store_in.index == 4'(q);
      assign clr_q = reg_wr && in_global && reg_addr == RXBUF_NEW_DATA_OFS && reg_wdata[q];
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          rxbuf_new_flag_r[q] <= 1'b0;
        end else if (set_q) begin
          rxbuf_new_flag_r[q] <= 1'b1;
        end else if (clr_q) begin
          rxbuf_new_flag_r[q] <= 1'b0;
        end
      end
    end
  endgenerate

  // One FIFO per entry: 0..7 reception FIFOs, 8..13 receive-mode TX/RX FIFOs
  genvar k;
  generate
    for (k = 0; k < FIFO_N; k++) begin : g_fifo
      crb_msg_t mem_r [DEPTH_MAX];
      logic [31:0] cfg_r;
      logic [7:0] count_r;
      logic [7:0] count_nxt;
      logic [2:0] wptr_r;
      logic [2:0] rptr_r;
      logic lost_r;
      logic irq_flag_r;
      logic enable;
      logic [3:0] depth;
      logic [3:0] fill_sel;
      logic full;
      logic empty;
      logic push_req;
      logic push;
      logic pop;
      logic cfg_wr;
      logic sts_wr;
      logic fill_hit;
      logic irq_set;

      assign enable = cfg_r[CFG_ENABLE_BIT];
      // Depth code 0..7 selects 1..8 messages
      assign depth = {1'b0, cfg_r[CFG_DEPTH_LSB +: 3]} + 4'h1;
      assign fill_sel = {1'b0, cfg_r[CFG_FILL_SEL_LSB +: 3]} + 4'h1;
      assign full = (count_r == {4'h0, depth});
      assign empty = (count_r == COUNT_RESET);
      assign cfg_wr = reg_wr && in_fifo && fifo_sel == 4'(k) && fifo_word == FIFO_CONFIG_IDX;
      assign sts_wr = reg_wr && in_fifo && fifo_sel == 4'(k) && fifo_word == FIFO_STATUS_IDX;
      assign push_req = store_in.valid && store_in.to_fifo && store_in.index == 4'(k) && enable;
      // A full FIFO drops the frame rather than overwrite the oldest
      assign push = push_req && !full;
      assign pop = reg_wr && in_fifo && fifo_sel == 4'(k) && fifo_word == FIFO_NEXT_IDX
                   && !empty && enable;

      always_comb begin
        count_nxt = count_r;
        if (push && !pop) begin
          count_nxt = count_r + 8'h01;
        end else if (pop && !push) begin
          count_nxt = count_r - 8'h01;
        end
      end

      // Fill level reached: count/depth at or above (sel+1)/8
      // Product kept at 8 bits, since 8 x 8 overflows four
      assign fill_hit = ({count_nxt, 3'b000} >= {3'b000, 8'(depth) * 8'(fill_sel)});
      assign irq_set = push && (cfg_r[CFG_IRQ_MODE_BIT] ? 1'b1 : fill_hit);

      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          cfg_r <= CONFIG_RESET;
        end else if (cfg_wr) begin
          cfg_r <= reg_wdata;
        end
      end

      always_ff @(posedge clk_sys) begin
        if (push) begin
          mem_r[wptr_r] <= store_in.msg;
        end
      end

      // Pointers; disabling the FIFO discards its contents
      always_ff @(posedge clk_sys) begin
        if (!rst_n || !enable) begin
          wptr_r <= 3'h0;
          rptr_r <= 3'h0;
          count_r <= COUNT_RESET;
        end else begin
          if (push) begin
            wptr_r <= (wptr_r == 3'(depth - 4'h1)) ? 3'h0 : wptr_r + 3'h1;
          end
          if (pop) begin
            rptr_r <= (rptr_r == 3'(depth - 4'h1)) ? 3'h0 : rptr_r + 3'h1;
          end
          count_r <= count_nxt;
        end
      end

      // Loss flag: set wins over a clear in the same cycle
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          lost_r <= 1'b0;
        end else if (push_req && full) begin
          lost_r <= 1'b1;
        end else if (sts_wr && reg_wdata[STS_LOST_BIT]) begin
          lost_r <= 1'b0;
        end
      end

      // Request flag survives disabling; only software clears it
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          irq_flag_r <= 1'b0;
        end else if (irq_set) begin
          irq_flag_r <= 1'b1;
        end else if (sts_wr && reg_wdata[STS_IRQ_FLAG_BIT]) begin
          irq_flag_r <= 1'b0;
        end
      end

      assign fifo_cfg[k] = cfg_r;
      assign fifo_head[k] = mem_r[rptr_r];
      assign fifo_lost[k] = lost_r;
      assign fifo_irq_req[k] = irq_flag_r && cfg_r[CFG_IRQ_ENABLE_BIT];
      assign fifo_sts[k] = {16'h0000, count_r, 4'h0, irq_flag_r, lost_r, full, empty};
    end
  endgenerate

  // Interrupt outputs registered so they come straight from flops
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fifo_irq_r <= '0;
    end else begin
      fifo_irq_r <= fifo_irq_req;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      global_err_irq_r <= 1'b0;
    end else begin
      global_err_irq_r <= msg_lost_irq_enable_r && (|fifo_lost);
    end
  end

  // Read data valid the cycle after the strobe; unmapped reads as zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_data_r <= 32'h0000_0000;
    end else if (reg_rd) begin
      rd_data_r <= 32'h0000_0000;
      if (in_global && reg_addr == GLOBAL_CONTROL_OFS) begin
        rd_data_r <= {31'h0000_0000, msg_lost_irq_enable_r};
      end else if (in_global && reg_addr == RXBUF_NEW_DATA_OFS) begin
        rd_data_r <= {24'h00_0000, rxbuf_new_flag_r};
      end else if (in_rxbuf) begin
        unique case (rxbuf_word)
          RXBUF_ID_IDX: rd_data_r <= rxbuf_mem_r[rxbuf_sel].id;
          RXBUF_POINTER_IDX: rd_data_r <= rxbuf_mem_r[rxbuf_sel].pointer;
          RXBUF_DATA_LO_IDX: rd_data_r <= rxbuf_mem_r[rxbuf_sel].data_lo;
          RXBUF_DATA_HI_IDX: rd_data_r <= rxbuf_mem_r[rxbuf_sel].data_hi;
        endcase
      end else if (in_fifo && fifo_sel_ok) begin
        case (fifo_word)
          FIFO_CONFIG_IDX: rd_data_r <= fifo_cfg[fifo_sel];
          FIFO_STATUS_IDX: rd_data_r <= fifo_sts[fifo_sel];
          FIFO_ID_IDX: rd_data_r <= fifo_head[fifo_sel].id;
          FIFO_POINTER_IDX: rd_data_r <= fifo_head[fifo_sel].pointer;
          FIFO_DATA_LO_IDX: rd_data_r <= fifo_head[fifo_sel].data_lo;
          FIFO_DATA_HI_IDX: rd_data_r <= fifo_head[fifo_sel].data_hi;
          default: rd_data_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign reg_rdata = rd_data_r;
  assign fifo_irq = fifo_irq_r;
  assign global_err_irq = global_err_irq_r;

endmodule // crb_rx_store

// file: core/crb_pkg.sv
// Shared constants and carrier types for the CAN receive storage block
package crb_pkg;

  localparam int RXBUF_N = 8;
  localparam int RXFIFO_N = 8;
  localparam int CHAN_N = 2;
  localparam int TRX_PER_CHAN = 3;
  localparam int FIFO_N = RXFIFO_N + CHAN_N * TRX_PER_CHAN;
  localparam int DEPTH_MAX = 8;

  // Global byte addresses and upper-address region codes of the register map
  localparam logic [11:0] GLOBAL_CONTROL_OFS = 12'h000;
  localparam logic [11:0] RXBUF_NEW_DATA_OFS = 12'h004;
  localparam logic [2:0] FIFO_REGION = 3'h1;
  localparam logic [4:0] RXBUF_REGION = 5'h08;

  // Word index inside one FIFO block (0x20 bytes each, from 0x200)
  localparam logic [2:0] FIFO_CONFIG_IDX = 3'h0;
  localparam logic [2:0] FIFO_STATUS_IDX = 3'h1;
  localparam logic [2:0] FIFO_ID_IDX = 3'h2;
  localparam logic [2:0] FIFO_POINTER_IDX = 3'h3;
  localparam logic [2:0] FIFO_DATA_LO_IDX = 3'h4;
  localparam logic [2:0] FIFO_DATA_HI_IDX = 3'h5;
  localparam logic [2:0] FIFO_NEXT_IDX = 3'h6;

  // Word index inside one buffer block (0x10 bytes each, from 0x400)
  localparam logic [1:0] RXBUF_ID_IDX = 2'h0;
  localparam logic [1:0] RXBUF_POINTER_IDX = 2'h1;
  localparam logic [1:0] RXBUF_DATA_LO_IDX = 2'h2;
  localparam logic [1:0] RXBUF_DATA_HI_IDX = 2'h3;

  // Config fields
  localparam int CFG_ENABLE_BIT = 0;
  localparam int CFG_IRQ_ENABLE_BIT = 1;
  localparam int CFG_IRQ_MODE_BIT = 2;
  localparam int CFG_DEPTH_LSB = 4;
  localparam int CFG_FILL_SEL_LSB = 8;

  // Status fields
  localparam int STS_EMPTY_BIT = 0;
  localparam int STS_FULL_BIT = 1;
  localparam int STS_LOST_BIT = 2;
  localparam int STS_IRQ_FLAG_BIT = 3;
  localparam int STS_COUNT_LSB = 8;

  localparam int GCTL_MSG_LOST_IRQ_ENABLE_BIT = 0;

  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [7:0] COUNT_RESET = 8'h00;

  typedef struct packed {
    logic [31:0] id;
    logic [31:0] pointer;
    logic [31:0] data_lo;
    logic [31:0] data_hi;
  } crb_msg_t;

  typedef struct packed {
    logic valid;
    logic to_fifo;
    logic [3:0] index;
    crb_msg_t msg;
  } crb_store_t;

endpackage

// file: bench/crb_rx_store_chk.sv
// Assertions on the ports of the receive storage block
`timescale 1ns/1ps
module crb_rx_store_chk
  import crb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire crb_store_t store_in,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [FIFO_N-1:0] fifo_irq,
  input wire logic global_err_irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_buf_store;
    store_in.valid && !store_in.to_fifo && !store_in.index[3];
  endsequence
  sequence s_buf_rd(logic [3:0] ofs);
    reg_rd && reg_addr == {4'h4, 1'b0, $past(store_in.index[2:0]), ofs};
  endsequence
  property p_buf_latest;
    s_buf_store ##1 s_buf_rd(4'h0) |=> reg_rdata == $past(store_in.msg.id, 2);
  endproperty
  a_buf_latest: assert property (p_buf_latest) else $error("buffer id not latest");
  property p_buf_data;
    s_buf_store ##1 s_buf_rd(4'hC) |=> reg_rdata == $past(store_in.msg.data_hi, 2);
  endproperty
  a_buf_data: assert property (p_buf_data) else $error("buffer data word wrong");
  property p_new_flag;
    s_buf_store ##1 (reg_rd && reg_addr == RXBUF_NEW_DATA_OFS)
      |=> reg_rdata[$past(store_in.index[2:0], 2)];
  endproperty
  a_new_flag: assert property (p_new_flag) else $error("new flag not set");
  // Write excluded since it may legally move an enable
  property p_buf_quiet;
    store_in.valid && !store_in.to_fifo && !reg_wr |=> ##1 $stable(fifo_irq);
  endproperty
  a_buf_quiet: assert property (p_buf_quiet) else $error("buffer store moved irq");
  property p_irq_rise;
    |(fifo_irq & ~$past(fifo_irq)) |-> $past(reg_wr || store_in.valid && store_in.to_fifo, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("fifo irq rose uncaused");
  property p_irq_hold;
    |(~fifo_irq & $past(fifo_irq)) |-> $past(reg_wr, 2) || !$past(rst_n);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("fifo irq dropped alone");
  property p_err_rise;
    $rose(global_err_irq) |-> $past(reg_wr || store_in.valid && store_in.to_fifo, 2);
  endproperty
  a_err_rise: assert property (p_err_rise) else $error("error irq rose uncaused");
  property p_err_fall;
    $fell(global_err_irq) |-> $past(reg_wr, 2) || !$past(rst_n);
  endproperty
  a_err_fall: assert property (p_err_fall) else $error("error irq dropped alone");
endmodule // crb_rx_store_chk
bind crb_rx_store crb_rx_store_chk i_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .store_in(store_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fifo_irq(fifo_irq),
  .global_err_irq(global_err_irq));

// file: bench/crb_rx_engine.sv
// Receive engine model handing whole frames to the store port
`timescale 1ns/1ps
module crb_rx_engine
  import crb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic go,
  input wire logic to_fifo,
  input wire logic [3:0] index,
  input wire crb_msg_t msg,
  output crb_store_t store_in
);
  initial store_in = '0;
  always @(posedge clk_sys) begin
    store_in.valid <= go;
    if (go) begin
      store_in.to_fifo <= to_fifo;
      store_in.index <= index;
      store_in.msg <= msg;
    end else begin
      // Idle port inverts the held frame every cycle
      store_in.msg <= ~store_in.msg;
    end
  end
endmodule // crb_rx_engine

// file: bench/crb_rx_store_bench.sv
// Self-checking bench for the receive storage block
`timescale 1ns/1ps
module crb_rx_store_bench
  import crb_pkg::*;
;
  logic clk_sys, rst_n, reg_wr, reg_rd, go, s_tf, global_err_irq, rd_d;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0] s_ix;
  logic [FIFO_N-1:0] fifo_irq;
  crb_msg_t s_msg, m;
  crb_store_t store_in;
  int n_fail, checked, seed, cycles, k;
  int ks[3] = '{0, 8, 13};
  logic [31:0] exp_q[$];
  string nm_q[$];
  crb_msg_t mq[$];
  crb_rx_engine i_crb_rx_engine (.clk_sys(clk_sys), .go(go), .to_fifo(s_tf), .index(s_ix),
    .msg(s_msg), .store_in(store_in));
  crb_rx_store i_crb_rx_store (.clk_sys(clk_sys), .rst_n(rst_n), .store_in(store_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fifo_irq(fifo_irq), .global_err_irq(global_err_irq));
  initial begin
    clk_sys = 0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Strobes stay with the next call, so no signal is assigned twice per step
  task automatic cyc(input logic w, input logic r, input logic [11:0] a,
    input logic [31:0] d = 0, input logic [31:0] e = 0, input string nm = "", input logic g = 0);
    if (r) begin
      exp_q.push_back(e);
      nm_q.push_back(nm);
    end
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    go <= g;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    cyc(1, 0, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    cyc(0, 1, a, 0, e, nm);
  endtask
  task automatic st(input logic tf, input logic [3:0] ix, input crb_msg_t mm);
    s_tf <= tf;
    s_ix <= ix;
    s_msg <= mm;
    cyc(0, 0, 0, 0, 0, "", 1);
    cyc(0, 0, 0);
  endtask
  // Irq outputs lag their cause by one edge
  task automatic ckl(input string nm, input logic [14:0] e);
    cyc(0, 0, 0);
    #1;
    ck(nm, 32'(e), 32'({fifo_irq, global_err_irq}));
  endtask
  function automatic logic [11:0] fa(input int f, input int i);
    return 12'(32'h200 + f * 32 + i * 4);
  endfunction
  function automatic crb_msg_t rmsg();
    return {$random(seed), $random(seed), $random(seed), $random(seed)};
  endfunction
  always @(posedge clk_sys) begin
    if (rd_d) ck(nm_q.pop_front(), exp_q.pop_front(), reg_rdata);
    rd_d = reg_rd;
    cycles++;
    if (cycles > 3000) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    seed = 19;
    {n_fail, checked, cycles, rd_d, rst_n, reg_wr, reg_rd, go, s_tf} = '0;
    {s_ix, s_msg, reg_addr, reg_wdata} = '0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1;
    @(posedge clk_sys);
    rd(fa(0, 0), CONFIG_RESET, "config reset");
    rd(12'hFFC, 32'h0, "unmapped");
    m = rmsg();
    st(0, 3, m);
    m = rmsg();
    st(0, 3, m);
    rd(RXBUF_NEW_DATA_OFS, 32'h8, "new flags");
    for (int i = 0; i < 4; i++) rd(12'(32'h430 + i * 4), m[127-32*i -: 32], "buffer");
    wr(RXBUF_NEW_DATA_OFS, 32'h8);
    rd(RXBUF_NEW_DATA_OFS, 32'h0, "new cleared");
    m = rmsg();
    st(0, 5, m);
    rd(12'h450, m[127:96], "buffer id");
    st(0, 5, m);
    rd(12'h45C, m[31:0], "buffer data hi");
    ckl("irq after buffer stores", 0);
    $display("test buffers done");
    for (int j = 0; j < 3; j++) begin
      k = ks[j];
      wr(fa(k, 1), 32'hC);
      wr(fa(k, 0), 32'h27);
      for (int n = 0; n < 4; n++) begin
        m = rmsg();
        if (n < 3) mq.push_back(m);
        st(1, k[3:0], m);
        if (n == 2) rd(fa(k, 1), 32'h30A, "status full");
      end
      rd(fa(k, 1), 32'h30E, "status lost");
      ckl("fifo irq", 15'(1 << (k + 1)));
      wr(GLOBAL_CONTROL_OFS, 32'h1);
      ckl("error irq", 15'((1 << (k + 1)) | 1));
      for (int n = 0; n < 3; n++) begin
        m = mq.pop_front();
        for (int i = 0; i < 4; i++) rd(fa(k, 2 + i), m[127-32*i -: 32], "fifo word");
        wr(fa(k, 6), 32'h0);
      end
      rd(fa(k, 1), 32'h00D, "status empty");
      wr(fa(k, 0), 32'h2);
      ckl("flag kept", 15'((1 << (k + 1)) | 1));
      wr(fa(k, 1), 32'hC);
      wr(GLOBAL_CONTROL_OFS, 32'h0);
      ckl("flags cleared", 0);
      $display("test fifo %0d done", k);
    end
    wr(fa(1, 0), 32'h373);
    for (int n = 0; n < 3; n++) st(1, 4'h1, rmsg());
    ckl("below fill", 0);
    st(1, 4'h1, rmsg());
    ckl("fill reached", 15'h4);
    wr(fa(1, 0), 32'h371);
    ckl("irq disabled", 0);
    rd(fa(1, 1), 32'h408, "fill status");
    $display("test fill level done");
    wrap_up();
  end
endmodule // crb_rx_store_bench
